/* File: udma_cfg.svh */
// Register offsets and descriptor layout for the micro DMA controller
`ifndef UDMA_CFG_SVH
`define UDMA_CFG_SVH
`define UDMA_REG_CFG 12'h000
`define UDMA_REG_BASE 12'h004
`define UDMA_REG_ENSET 12'h008
`define UDMA_REG_ENCLR 12'h00c
`define UDMA_REG_SWREQ 12'h010
`define UDMA_REG_MASK 12'h014
`define UDMA_REG_PRIO 12'h018
`define UDMA_REG_ALT 12'h01c
`define UDMA_REG_STAT 12'h020
`define UDMA_BASE_LSB 10
`define UDMA_ALT_OFS 32'h0000_0200
`define UDMA_DESC_SHIFT 4
`define UDMA_MODE_HI 2
`define UDMA_SIZE_HI 5
`define UDMA_SIZE_LO 4
`define UDMA_SINC_HI 7
`define UDMA_SINC_LO 6
`define UDMA_DINC_HI 9
`define UDMA_DINC_LO 8
`define UDMA_CNT_HI 25
`define UDMA_CNT_LO 16
`define UDMA_TASK_WORDS 2'h3
`define UDMA_LAST_WORD 2'h2
`define UDMA_INC_NONE 2'h3
`define UDMA_WORD_SIZE 2'h2
`endif

/* File: udma_pkg.sv */
// Types shared by the micro DMA controller
package udma_pkg;
  // Transfer modes held in the descriptor control word
  typedef enum logic [2:0] {
    M_STOP = 3'h0, M_BASIC = 3'h1, M_AUTO = 3'h2, M_PING = 3'h3,
    M_MSG = 3'h4, M_MSG_ALT = 3'h5, M_PSG = 3'h6, M_PSG_ALT = 3'h7
  } udma_mode_t;
  // Engine states
  typedef enum logic [2:0] {
    S_IDLE = 3'h0, S_FETCH = 3'h1, S_RD = 3'h2, S_WR = 3'h3, S_WB = 3'h4
  } udma_state_t;
  // Request to the system memory bus
  typedef struct packed {
    logic req;
    logic we;
    logic [1:0] size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } udma_mreq_t;
endpackage : udma_pkg

/* File: udma_ctrl.sv */
// Micro DMA controller: APB registers, arbiter and transfer engine
//
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "udma_cfg.svh"
module udma_ctrl #(
  parameter int NCH = 4,
  parameter int SWCH = 3
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Peripheral requests
  input wire logic [NCH-1:0] dma_req,
  // Memory bus master
  output udma_pkg::udma_mreq_t mreq,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  input wire logic cpu_busy,
  // Completion
  output logic [NCH-1:0] chan_done
);
  localparam int CW = (NCH > 1) ? $clog2(NCH) : 1;
  localparam logic [NCH-1:0] SWBIT = NCH'(1) << SWCH;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Address step by increment code
  function automatic logic [31:0] step(input logic [31:0] a, input logic [1:0] c);
    step = (c == `UDMA_INC_NONE) ? a : a + (32'h1 << c);
  endfunction : step

  // Lowest set bit of a request vector
  function automatic logic [CW-1:0] pick(input logic [NCH-1:0] v);
    pick = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (v[i]) begin
        pick = CW'(i);
      end
    end
  endfunction : pick

  // ----------------------------------------
  // State
  // ----------------------------------------
  udma_pkg::udma_state_t st_r, st_nxt;
  udma_pkg::udma_mreq_t mreq_r, mreq_nxt;
  logic [CW-1:0] ch_r, ch_nxt;
  logic [31:0] src_r, src_nxt, dst_r, dst_nxt, ctl_r, ctl_nxt, dat_r, dat_nxt;
  logic [1:0] widx_r, widx_nxt, chunk_r, chunk_nxt;
  logic fin_r, fin_nxt, gen_r, gen_nxt;
  logic [31:`UDMA_BASE_LSB] base_r, base_nxt;
  logic [NCH-1:0] en_r, en_nxt, run_r, run_nxt, mask_r, mask_nxt;
  logic [NCH-1:0] prio_r, prio_nxt, alt_r, alt_nxt, done_r, done_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic [NCH-1:0] hreq, elig;
  logic [9:0] cnt;
  udma_pkg::udma_mode_t mode;
  logic ack, live;

  // Request qualification
  assign hreq = dma_req & ~mask_r & ~SWBIT;
  assign elig = en_r & (run_r | hreq) & {NCH{gen_r}};
  assign cnt = ctl_r[`UDMA_CNT_HI:`UDMA_CNT_LO];
  assign mode = udma_pkg::udma_mode_t'(ctl_r[`UDMA_MODE_HI:0]);
  assign ack = mreq_r.req & mem_ack;
  assign live = run_r[ch_r] | hreq[ch_r];

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [31:0] daddr;
    logic acc, wr, endt;
    daddr = '0;
    acc = 1'b0;
    wr = 1'b0;
    endt = 1'b0;
    st_nxt = st_r;
    mreq_nxt = mreq_r;
    ch_nxt = ch_r;
    src_nxt = src_r;
    dst_nxt = dst_r;
    ctl_nxt = ctl_r;
    dat_nxt = dat_r;
    widx_nxt = widx_r;
    chunk_nxt = chunk_r;
    fin_nxt = fin_r;
    gen_nxt = gen_r;
    base_nxt = base_r;
    en_nxt = en_r;
    run_nxt = run_r;
    mask_nxt = mask_r;
    prio_nxt = prio_r;
    alt_nxt = alt_r;
    done_nxt = '0;
    // Descriptor word address
    daddr = {base_r, `UDMA_BASE_LSB'(0)} + (alt_r[ch_r] ? `UDMA_ALT_OFS : 32'h0)
      + (32'(ch_r) << `UDMA_DESC_SHIFT) + {28'h0, widx_r, 2'h0};
    // Issue only while the processor leaves the bus
    if (!mreq_r.req && !cpu_busy && st_r != udma_pkg::S_IDLE) begin
      mreq_nxt.req = 1'b1;
      mreq_nxt.we = (st_r == udma_pkg::S_WR) || (st_r == udma_pkg::S_WB);
      mreq_nxt.size = `UDMA_WORD_SIZE;
      mreq_nxt.addr = daddr;
      mreq_nxt.wdata = (widx_r == 2'h0) ? src_r : (widx_r == 2'h1) ? dst_r : ctl_r;
      if (st_r == udma_pkg::S_RD) begin
        mreq_nxt.size = ctl_r[`UDMA_SIZE_HI:`UDMA_SIZE_LO];
        mreq_nxt.addr = src_r;
      end else if (st_r == udma_pkg::S_WR) begin
        mreq_nxt.size = ctl_r[`UDMA_SIZE_HI:`UDMA_SIZE_LO];
        mreq_nxt.addr = dst_r;
        mreq_nxt.wdata = dat_r;
      end
    end else if (ack) begin
      mreq_nxt.req = 1'b0;
    end
    // Engine
    case (st_r)
      udma_pkg::S_IDLE: begin
        if (|elig) begin
          ch_nxt = (|(elig & prio_r)) ? pick(elig & prio_r) : pick(elig);
          widx_nxt = 2'h0;
          st_nxt = udma_pkg::S_FETCH;
        end
      end
      udma_pkg::S_FETCH: begin
        if (ack) begin
          widx_nxt = widx_r + 2'h1;
          if (widx_r == 2'h0) begin
            src_nxt = mem_rdata;
          end else if (widx_r == 2'h1) begin
            dst_nxt = mem_rdata;
          end else begin
            ctl_nxt = mem_rdata;
            widx_nxt = 2'h0;
            chunk_nxt = 2'h0;
            st_nxt = udma_pkg::S_RD;
            // Stopped or empty descriptor ends the channel
            if (mem_rdata[`UDMA_MODE_HI:0] == udma_pkg::M_STOP
                || mem_rdata[`UDMA_CNT_HI:`UDMA_CNT_LO] == 10'h0) begin
              en_nxt[ch_r] = 1'b0;
              run_nxt[ch_r] = 1'b0;
              st_nxt = udma_pkg::S_IDLE;
            end else if (mem_rdata[`UDMA_MODE_HI:0] == udma_pkg::M_AUTO
                || mem_rdata[`UDMA_MODE_HI:1] == 2'h2) begin
              run_nxt[ch_r] = 1'b1;
            end
          end
        end
      end
      udma_pkg::S_RD: begin
        if (ack) begin
          dat_nxt = mem_rdata;
          src_nxt = step(src_r, ctl_r[`UDMA_SINC_HI:`UDMA_SINC_LO]);
          st_nxt = udma_pkg::S_WR;
        end
      end
      udma_pkg::S_WR: begin
        if (ack) begin
          dst_nxt = step(dst_r, ctl_r[`UDMA_DINC_HI:`UDMA_DINC_LO]);
          ctl_nxt[`UDMA_CNT_HI:`UDMA_CNT_LO] = cnt - 10'h1;
          chunk_nxt = chunk_r + 2'h1;
          // Primary list copy hands over after each task
          endt = mode[2] && !alt_r[ch_r] && chunk_nxt == `UDMA_TASK_WORDS;
          if (cnt == 10'h1 || endt) begin
            fin_nxt = 1'b1;
            st_nxt = udma_pkg::S_WB;
          end else if (gen_r && en_r[ch_r] && live) begin
            st_nxt = udma_pkg::S_RD;
          end else begin
            fin_nxt = 1'b0;
            st_nxt = udma_pkg::S_WB;
          end
        end
      end
      udma_pkg::S_WB: begin
        if (ack) begin
          widx_nxt = widx_r + 2'h1;
          if (widx_r == `UDMA_LAST_WORD) begin
            widx_nxt = 2'h0;
            st_nxt = udma_pkg::S_IDLE;
            if (fin_r) begin
              if (mode[2] && !alt_r[ch_r]) begin
                alt_nxt[ch_r] = 1'b1;
              end else if (mode == udma_pkg::M_PING) begin
                done_nxt[ch_r] = 1'b1;
                alt_nxt[ch_r] = ~alt_r[ch_r];
              end else if (mode[2] && mode[0]) begin
                alt_nxt[ch_r] = 1'b0;
              end else begin
                done_nxt[ch_r] = 1'b1;
                en_nxt[ch_r] = 1'b0;
                run_nxt[ch_r] = 1'b0;
                alt_nxt[ch_r] = 1'b0;
              end
            end
          end
        end
      end
      default: begin
        st_nxt = udma_pkg::S_IDLE;
      end
    endcase
    // APB: one wait state, write lands on the ready edge
    acc = psel & penable & ~pready_r;
    wr = psel & penable & pready_r & pwrite;
    pready_nxt = acc;
    prdata_nxt = '0;
    pslverr_nxt = 1'b0;
    if (acc) begin
      case (paddr)
        `UDMA_REG_CFG: prdata_nxt = {31'h0, gen_r};
        `UDMA_REG_BASE: prdata_nxt = {base_r, `UDMA_BASE_LSB'(0)};
        `UDMA_REG_ENSET: prdata_nxt = 32'(en_r);
        `UDMA_REG_ENCLR: prdata_nxt = 32'h0;
        `UDMA_REG_SWREQ: prdata_nxt = 32'(run_r);
        `UDMA_REG_MASK: prdata_nxt = 32'(mask_r);
        `UDMA_REG_PRIO: prdata_nxt = 32'(prio_r);
        `UDMA_REG_ALT: prdata_nxt = 32'(alt_r);
        `UDMA_REG_STAT: prdata_nxt = {15'h0, st_r != udma_pkg::S_IDLE, 8'h0, 8'(ch_r)};
        default: pslverr_nxt = 1'b1;
      endcase
    end
    // Software writes after hardware, so a set wins
    if (wr) begin
      case (paddr)
        `UDMA_REG_CFG: gen_nxt = pwdata[0];
        `UDMA_REG_BASE: base_nxt = pwdata[31:`UDMA_BASE_LSB];
        `UDMA_REG_ENSET: en_nxt = en_nxt | pwdata[NCH-1:0];
        `UDMA_REG_ENCLR: en_nxt = en_nxt & ~pwdata[NCH-1:0];
        `UDMA_REG_SWREQ: run_nxt = run_nxt | pwdata[NCH-1:0];
        `UDMA_REG_MASK: mask_nxt = pwdata[NCH-1:0];
        `UDMA_REG_PRIO: prio_nxt = pwdata[NCH-1:0];
        `UDMA_REG_ALT: alt_nxt = pwdata[NCH-1:0];
        default: mask_nxt = mask_nxt; // Unmapped writes are dropped
      endcase
    end
    // Global disable drops pending software starts
    if (!gen_nxt) begin
      run_nxt = '0;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= udma_pkg::S_IDLE;
      mreq_r <= '0;
      ch_r <= '0;
      src_r <= '0;
      dst_r <= '0;
      ctl_r <= '0;
      dat_r <= '0;
      widx_r <= '0;
      chunk_r <= '0;
      fin_r <= 1'b0;
      gen_r <= 1'b0;
      base_r <= '0;
      en_r <= '0;
      run_r <= '0;
      mask_r <= '0;
      prio_r <= '0;
      alt_r <= '0;
      done_r <= '0;
      prdata_r <= '0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      mreq_r <= mreq_nxt;
      ch_r <= ch_nxt;
      src_r <= src_nxt;
      dst_r <= dst_nxt;
      ctl_r <= ctl_nxt;
      dat_r <= dat_nxt;
      widx_r <= widx_nxt;
      chunk_r <= chunk_nxt;
      fin_r <= fin_nxt;
      gen_r <= gen_nxt;
      base_r <= base_nxt;
      en_r <= en_nxt;
      run_r <= run_nxt;
      mask_r <= mask_nxt;
      prio_r <= prio_nxt;
      alt_r <= alt_nxt;
      done_r <= done_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // Outputs
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign mreq = mreq_r;
  assign chan_done = done_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_cpu_first;
    $rose(mreq_r.req) |-> !$past(cpu_busy);
  endproperty
  a_cpu_first: assert property (p_cpu_first) else $error("bus taken while cpu busy");

  property p_gen_off;
    (st_r == udma_pkg::S_IDLE && !gen_r) |=> st_r == udma_pkg::S_IDLE;
  endproperty
  a_gen_off: assert property (p_gen_off) else $error("started while disabled");

  property p_hi_first;
    (st_r == udma_pkg::S_IDLE && |(elig & prio_r)) |=> prio_r[ch_r];
  endproperty
  a_hi_first: assert property (p_hi_first) else $error("low priority won");

  property p_elig;
    (st_r == udma_pkg::S_FETCH && $past(st_r) == udma_pkg::S_IDLE)
      |-> |($past(elig) & (NCH'(1) << ch_r));
  endproperty
  a_elig: assert property (p_elig) else $error("masked or idle channel started");

  property p_count;
    (st_r == udma_pkg::S_WR && ack) |=> cnt == $past(cnt) - 10'h1;
  endproperty
  a_count: assert property (p_count) else $error("count not decremented");

  property p_fixed_src;
    (ack && ((st_r == udma_pkg::S_RD && ctl_r[`UDMA_SINC_HI:`UDMA_SINC_LO] == 2'h3)
      || (st_r == udma_pkg::S_WR && ctl_r[`UDMA_DINC_HI:`UDMA_DINC_LO] == 2'h3)))
      |=> $stable(src_r) && $stable(dst_r);
  endproperty
  a_fixed_src: assert property (p_fixed_src) else $error("fixed address moved");

  property p_size;
    (mreq_r.req && (st_r == udma_pkg::S_RD || st_r == udma_pkg::S_WR))
      |-> mreq_r.size == ctl_r[`UDMA_SIZE_HI:`UDMA_SIZE_LO];
  endproperty
  a_size: assert property (p_size) else $error("wrong item size");

  property p_basic_pause;
    (st_r == udma_pkg::S_WR && ack && mode == udma_pkg::M_BASIC && !live && cnt > 10'h1)
      |=> st_r == udma_pkg::S_WB ##1 !fin_r;
  endproperty
  a_basic_pause: assert property (p_basic_pause) else $error("basic ran without request");

  property p_auto_done;
    (st_r == udma_pkg::S_WB && ack && fin_r && widx_r == 2'h2 && mode == udma_pkg::M_AUTO)
      |=> !en_r[$past(ch_r)] && chan_done[$past(ch_r)];
  endproperty
  a_auto_done: assert property (p_auto_done) else $error("enable kept after done");

endmodule : udma_ctrl

/* File: udma_mem_model.sv */
// Behavioural system memory that answers the engine's bus requests
`timescale 1ns/1ps
module udma_mem_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Engine bus
  input wire udma_pkg::udma_mreq_t mreq,
  output logic mem_ack,
  output logic [31:0] mem_rdata,
  // Answer delay in cycles
  input wire logic [1:0] stall
);
  logic [7:0] mem [0:4095];
  logic [1:0] wait_r;
  logic [11:0] a;
  assign a = mreq.addr[11:0] & 12'hffc;
  // Ack after the stall; idle data flips so a stale word never looks valid
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      mem_rdata <= 32'h0;
      wait_r <= 2'h0;
    end else if (mreq.req && !mem_ack && wait_r >= stall) begin
      mem_ack <= 1'b1;
      wait_r <= 2'h0;
      mem_rdata <= {mem[a+3], mem[a+2], mem[a+1], mem[a]};
      // Only the lanes of the item size are written
      for (int k = 0; k < 4; k++) begin
        if (mreq.we && (mreq.size == 2'h2 || (mreq.size == 2'h1 && k[1] == mreq.addr[1])
            || k[1:0] == mreq.addr[1:0])) begin
          mem[a+k] <= mreq.wdata[8*k +: 8];
        end
      end
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mreq.req && !mem_ack) wait_r <= wait_r + 2'h1;
    end
  end
endmodule : udma_mem_model

/* File: micro_dma_controller_test.sv */
// Bench for the micro DMA controller: APB master, requests, result monitor
`timescale 1ns/1ps
`include "udma_cfg.svh"
`define CHK(what, exp, got) begin checks_done++; if ((got) !== (exp)) begin n_errors++; \
  $display("unexpected %s: expected %h seen %h", what, exp, got); end end
module micro_dma_controller_test;
  // Aligned control table of 1024 bytes
  localparam logic [11:0] TBL = 12'h400;
  logic pclk, presetn, psel, penable, pwrite, mem_ack, cpu_busy, pready, pslverr, bq, rq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, mem_rdata, w;
  logic [31:0] lfsr = 32'h33217beb;
  logic [3:0] dma_req, chan_done, ed;
  logic [1:0] stall;
  logic [32:0] er;
  logic [32:0] exp_rd [$];
  logic [3:0] exp_done [$];
  int n_errors, checks_done, n;
  udma_pkg::udma_mreq_t mreq;
  // Design and memory partner
  udma_ctrl #(.NCH(4), .SWCH(3)) u_udma_ctrl (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dma_req(dma_req), .mreq(mreq), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .cpu_busy(cpu_busy), .chan_done(chan_done));
  udma_mem_model u_udma_mem_model (.pclk(pclk), .presetn(presetn), .mreq(mreq),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .stall(stall));
  // Clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nxt
  // Random processor traffic and memory stalls
  always @(posedge pclk) begin
    lfsr <= nxt(lfsr);
    cpu_busy <= lfsr[3] & lfsr[7];
    stall <= lfsr[5:4];
  end
  // Monitor: each result against the oldest note
  always @(negedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      er = exp_rd.pop_front();
      `CHK("read", er, {pslverr, prdata})
    end
    if (chan_done !== 4'h0) begin
      ed = exp_done.pop_front();
      `CHK("done", ed, chan_done)
    end
    if (mreq.req && !rq && bq) `CHK("bus grab", 1'b0, 1'b1)
    rq = mreq.req;
    bq = cpu_busy;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test
  // APB transfer held until pready is seen at a falling edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) begin
      n_errors++;
      finish_test();
    end
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    exp_rd.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd
  // Backdoor access to the partner memory
  task automatic poke(input logic [11:0] a, input logic [31:0] d);
    for (int k = 0; k < 4; k++) u_udma_mem_model.mem[a+k] = d[8*k +: 8];
  endtask : poke
  function automatic logic [31:0] peek(input logic [11:0] a);
    for (int k = 0; k < 4; k++) peek[8*k +: 8] = u_udma_mem_model.mem[a+k];
  endfunction : peek
  function automatic logic [15:0] diff(input logic [11:0] a, input int c);
    diff = 16'h0;
    // Byte by byte, so a copy is never credited with its neighbour's bytes
    for (int k = 0; k < c; k++) begin
      diff += 16'(u_udma_mem_model.mem[a + 12'(k)]
        !== u_udma_mem_model.mem[a + 12'h400 + 12'(k)]);
    end
  endfunction : diff
  // Random source words, inverted destination
  task automatic init();
    for (int k = 0; k < 8; k++) begin
      w = nxt(lfsr ^ k);
      poke(12'h900 + 12'(4 * k), w);
      poke(12'hd00 + 12'(4 * k), ~w);
    end
  endtask : init
  task automatic desc(input int ch, input logic alt, input logic [11:0] o,
    input udma_pkg::udma_mode_t m, input logic [1:0] sz, input logic [1:0] di,
    input logic [9:0] c);
    logic [11:0] b;
    b = TBL + (alt ? 12'h200 : 12'h0) + 12'(ch * 16);
    poke(b, {20'h0, 12'h900 + o});
    poke(b + 12'h4, {20'h0, 12'hd00 + o});
    poke(b + 12'h8, {6'h0, c, 6'h0, di, sz, sz, 1'b0, m});
  endtask : desc
  task automatic wait_done();
    n = 0;
    while (exp_done.size() != 0 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 3000) begin
      n_errors++;
      $display("unexpected completion: expected pulse seen none");
      finish_test();
    end
  endtask : wait_done
  task automatic go(input logic [3:0] m);
    wr(`UDMA_REG_ENSET, {28'h0, m});
    exp_done.push_back(m);
    wr(`UDMA_REG_SWREQ, {28'h0, m});
    wait_done();
  endtask : go
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, dma_req, cpu_busy, stall} = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(`UDMA_REG_CFG, 33'h0);
    rd(`UDMA_REG_ENSET, 33'h0);
    rd(`UDMA_REG_MASK, 33'h0);
    rd(`UDMA_REG_PRIO, 33'h0);
    rd(`UDMA_REG_ALT, 33'h0);
    rd(12'h040, {1'b1, 32'h0});
    wr(`UDMA_REG_CFG, 32'h1);
    wr(`UDMA_REG_BASE, {20'h0, TBL});
    rd(`UDMA_REG_BASE, {21'h0, TBL});
    $display("test registers done");
    // Software channel, auto mode, count written back as zero
    init();
    desc(3, 1'b0, 12'h0, udma_pkg::M_AUTO, 2'h2, 2'h2, 10'd4);
    go(4'h8);
    `CHK("copy", 16'h0, diff(12'h900, 16))
    w = peek(TBL + 12'h38);
    `CHK("count", 10'h0, w[25:16])
    rd(`UDMA_REG_ENSET, 33'h0);
    rd(`UDMA_REG_STAT, 33'h3);
    // Item sizes, then a fixed destination
    for (int s = 0; s < 4; s++) begin
      init();
      desc(1, 1'b0, 12'h0, udma_pkg::M_AUTO, s == 3 ? 2'h2 : 2'(s),
        s == 3 ? `UDMA_INC_NONE : 2'(s), 10'd4);
      go(4'h2);
      if (s < 3) `CHK("sized copy", 16'h0, diff(12'h900, 4 << s))
      if (s < 3) `CHK("past end", 16'h1, diff(12'h900 + 12'(4 << s), 1))
    end
    `CHK("fixed dst", peek(12'h90c), peek(12'hd00))
    `CHK("fixed dst next", ~peek(12'h904), peek(12'hd04))
    $display("test auto done");
    // Priority level first, then lowest channel
    for (int p = 0; p < 2; p++) begin
      init();
      desc(1, 1'b0, 12'h0, udma_pkg::M_AUTO, 2'h2, 2'h2, 10'd4);
      desc(2, 1'b0, 12'h10, udma_pkg::M_AUTO, 2'h2, 2'h2, 10'd4);
      wr(`UDMA_REG_PRIO, p ? 32'h4 : 32'h0);
      wr(`UDMA_REG_ENSET, 32'h6);
      exp_done.push_back(p ? 4'h4 : 4'h2);
      exp_done.push_back(p ? 4'h2 : 4'h4);
      wr(`UDMA_REG_SWREQ, 32'h6);
      wait_done();
    end
    wr(`UDMA_REG_ENSET, 32'h6);
    wr(`UDMA_REG_ENCLR, 32'h2);
    rd(`UDMA_REG_ENSET, 33'h4);
    wr(`UDMA_REG_ENCLR, 32'h4);
    $display("test priority done");
    // Memory scatter/gather: one task copied to the alternate slot, then run
    init();
    poke(12'ha00, 32'h0000_0900);
    poke(12'ha04, 32'h0000_0d00);
    poke(12'ha08, 32'h0004_02a2); // Task: four words in auto mode
    desc(1, 1'b0, 12'h0, udma_pkg::M_MSG, 2'h2, 2'h2, 10'd3);
    poke(TBL + 12'h10, 32'h0000_0a00);
    poke(TBL + 12'h14, {20'h0, TBL + 12'h210});
    go(4'h2);
    `CHK("gather copy", 16'h0, diff(12'h900, 16))
    rd(`UDMA_REG_ALT, 33'h0);
    // Basic mode: masked, then paused when the request drops
    init();
    desc(0, 1'b0, 12'h0, udma_pkg::M_BASIC, 2'h2, 2'h2, 10'd4);
    wr(`UDMA_REG_MASK, 32'h1);
    wr(`UDMA_REG_ENSET, 32'h1);
    dma_req <= {lfsr[3:1], 1'b1};
    repeat (40) @(posedge pclk);
    `CHK("masked", ~peek(12'h900), peek(12'hd00))
    wr(`UDMA_REG_MASK, 32'h0);
    for (n = 0; n < 2000 && peek(12'hd00) !== peek(12'h900); n++) @(posedge pclk);
    dma_req <= 4'h0;
    repeat (40) @(posedge pclk);
    `CHK("paused", ~peek(12'h90c), peek(12'hd0c))
    rd(`UDMA_REG_ENSET, 33'h1);
    exp_done.push_back(4'h1);
    dma_req <= 4'h1;
    wait_done();
    `CHK("resumed", 16'h0, diff(12'h900, 16))
    // Ping-pong over primary and alternate
    init();
    desc(0, 1'b0, 12'h0, udma_pkg::M_PING, 2'h2, 2'h2, 10'd2);
    desc(0, 1'b1, 12'h8, udma_pkg::M_PING, 2'h2, 2'h2, 10'd2);
    wr(`UDMA_REG_ENSET, 32'h1);
    exp_done.push_back(4'h1);
    exp_done.push_back(4'h1);
    wait_done();
    dma_req <= 4'h0;
    `CHK("ping pong", 16'h0, diff(12'h900, 16))
    wr(`UDMA_REG_ENCLR, 32'h1);
    $display("test basic done");
    // Global enable off, and the software channel's line ignored
    wr(`UDMA_REG_CFG, 32'h0);
    init();
    desc(0, 1'b0, 12'h0, udma_pkg::M_BASIC, 2'h2, 2'h2, 10'd4);
    desc(3, 1'b0, 12'h10, udma_pkg::M_AUTO, 2'h2, 2'h2, 10'd4);
    wr(`UDMA_REG_ENSET, 32'h9);
    dma_req <= 4'h9;
    repeat (40) @(posedge pclk);
    `CHK("disabled", ~peek(12'h900), peek(12'hd00))
    exp_done.push_back(4'h1);
    wr(`UDMA_REG_CFG, 32'h1);
    wait_done();
    repeat (60) @(posedge pclk);
    rd(`UDMA_REG_ENSET, 33'h8);
    dma_req <= 4'h0;
    wr(`UDMA_REG_ENCLR, 32'h8);
    $display("test enable done");
    finish_test();
  end
endmodule : micro_dma_controller_test
